// ===== logic/ast_regs.vh
`ifndef AST_REGS_VH
`define AST_REGS_VH

// Register word offsets on the plain register port.
`define AST_OFF_CTRL      4'h0
`define AST_OFF_TXDATA    4'h1
`define AST_OFF_RXDATA    4'h2
`define AST_OFF_STATUS    4'h3
`define AST_OFF_IRQ_STAT  4'h4
`define AST_OFF_IRQ_MASK  4'h5

// Control register fields.
`define AST_CTRL_LEN_LSB  0
`define AST_CTRL_LEN_MSB  1
`define AST_CTRL_NOPAR    2
`define AST_CTRL_EVEN     3
`define AST_CTRL_TWOSTOP  4
`define AST_CTRL_RST      5'h04

// Status register fields.
`define AST_ST_TBMT       0
`define AST_ST_EOC        1
`define AST_ST_AVAIL      2
`define AST_ST_PERR       3
`define AST_ST_FERR       4
`define AST_ST_OVR        5

// Interrupt event fields.
`define AST_IRQ_TBMT      0
`define AST_IRQ_EOC       1
`define AST_IRQ_AVAIL     2
`define AST_IRQ_ERR       3
`define AST_IRQ_RST       4'h0

// Bit timing in bit clock periods.
`define AST_TICKS_BIT     4'hF
`define AST_TICKS_START   4'h7

`endif

// ===== logic/ast_transceiver.v
`timescale 1ns/10ps
`include "ast_regs.vh"

module ast_transceiver #(
	parameter AW = 4
) (
	input  wire          sys_clk,                 // System clock, 25 MHz.
	input  wire          rst_n,                   // Async reset, active low.
	input  wire [AW-1:0] reg_addr,                // Register word address.
	input  wire [7:0]    reg_wdata,               // Register write data.
	input  wire          reg_wr,                  // Write strobe.
	input  wire          reg_rd,                  // Read strobe.
	output reg  [7:0]    reg_rdata_q,             // Read data, next cycle.
	output reg           irq_q,                   // Interrupt level.
	input  wire          tx_bit_clock,            // Transmit 16x clock pin.
	input  wire          rx_bit_clock,            // Receive 16x clock pin.
	input  wire          external_clear,          // Clear pin, active high.
	input  wire          serial_in,               // Serial receive pin.
	output reg           serial_out_q,            // Serial transmit pin.
	input  wire          rx_word_output_enable_n, // Data group enable.
	input  wire          flag_word_output_enable_n, // Flag group enable.
	output reg  [7:0]    rx_word_q,               // Gated received data.
	output reg  [4:0]    flag_word_q,             // Gated status flags.
	output reg           rx_word_available_q      // Received data ready.
);

	localparam TX_IDLE  = 1'b0;
	localparam TX_SHIFT = 1'b1;
	localparam RX_IDLE  = 2'd0;
	localparam RX_START = 2'd1;
	localparam RX_DATA  = 2'd2;
	localparam RX_XFER  = 2'd3;

	// Pin inputs pass two flops; the third stage feeds the edge detectors.
	reg  [2:0]  tck_s_q;
	reg  [2:0]  rck_s_q;
	reg  [1:0]  clr_s_q;
	reg  [1:0]  sin_s_q;
	reg  [1:0]  rde_s_q;
	reg  [1:0]  swe_s_q;
	wire        tx_tick;
	wire        rx_tick;
	wire        clr;
	wire        rx_line;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tck_s_q <= 3'h0;
			rck_s_q <= 3'h0;
			clr_s_q <= 2'h0;
			sin_s_q <= 2'h3;
			rde_s_q <= 2'h3;
			swe_s_q <= 2'h3;
		end else begin
			tck_s_q <= {tck_s_q[1:0], tx_bit_clock};
			rck_s_q <= {rck_s_q[1:0], rx_bit_clock};
			clr_s_q <= {clr_s_q[0], external_clear};
			sin_s_q <= {sin_s_q[0], serial_in};
			rde_s_q <= {rde_s_q[0], rx_word_output_enable_n};
			swe_s_q <= {swe_s_q[0], flag_word_output_enable_n};
		end
	end

	assign tx_tick = tck_s_q[1] & ~tck_s_q[2];
	assign rx_tick = rck_s_q[1] & ~rck_s_q[2];
	assign clr     = clr_s_q[1];
	assign rx_line = sin_s_q[1];

	// Control word written by the host.
	reg  [4:0]  ctrl_q;
	wire [3:0]  len;
	wire        par_en;
	wire [7:0]  len_mask;

	assign len      = 4'h5 +
		{2'b00, ctrl_q[`AST_CTRL_LEN_MSB:`AST_CTRL_LEN_LSB]};
	assign par_en   = ~ctrl_q[`AST_CTRL_NOPAR];
	assign len_mask = 8'hFF >> (4'h8 - len);

	wire        wr_ctrl = reg_wr && reg_addr == `AST_OFF_CTRL;
	wire        wr_tx   = reg_wr && reg_addr == `AST_OFF_TXDATA;
	wire        rd_rx   = reg_rd && reg_addr == `AST_OFF_RXDATA;
	wire        rd_irq  = reg_rd && reg_addr == `AST_OFF_IRQ_STAT;

	// Transmitter: holding register feeding a framed shift register.
	reg  [7:0]  hold_q;
	reg         hold_full_q;
	reg         tx_st_q;
	reg  [11:0] frame_q;
	reg  [3:0]  tx_sub_q;
	reg  [3:0]  tx_bits_q;
	reg         eoc_q;
	reg  [11:0] frame_d;
	reg  [3:0]  nbits_d;
	integer     i;

	// Start bit, data LSB first, optional parity, mark stops fill the rest.
	always @* begin
		frame_d    = 12'hFFF;
		frame_d[0] = 1'b0;
		for (i = 0; i < 8; i = i + 1)
			if (i < len)
				frame_d[i + 1] = hold_q[i];
		if (par_en)
			frame_d[len + 4'h1] = ^(hold_q & len_mask) ^
				~ctrl_q[`AST_CTRL_EVEN];
		nbits_d = 4'h2 + len + {3'b000, par_en} +
			{3'b000, ctrl_q[`AST_CTRL_TWOSTOP]};
	end

	wire tx_last = tx_st_q == TX_SHIFT && tx_tick &&
		tx_sub_q == `AST_TICKS_BIT && tx_bits_q == 4'h1;
	wire tx_load = hold_full_q && tx_tick &&
		(tx_st_q == TX_IDLE || tx_last);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q       <= `AST_CTRL_RST;
			hold_q       <= 8'h00;
			hold_full_q  <= 1'b0;
			tx_st_q      <= TX_IDLE;
			frame_q      <= 12'hFFF;
			tx_sub_q     <= 4'h0;
			tx_bits_q    <= 4'h0;
			eoc_q        <= 1'b1;
			serial_out_q <= 1'b1;
		end else if (clr) begin
			ctrl_q       <= `AST_CTRL_RST;
			hold_q       <= 8'h00;
			hold_full_q  <= 1'b0;
			tx_st_q      <= TX_IDLE;
			frame_q      <= 12'hFFF;
			tx_sub_q     <= 4'h0;
			tx_bits_q    <= 4'h0;
			eoc_q        <= 1'b1;
			serial_out_q <= 1'b1;
		end else begin
			if (wr_ctrl)
				ctrl_q <= reg_wdata[4:0];
			// A load while full overwrites; the host watches the empty flag.
			if (wr_tx) begin
				hold_q      <= reg_wdata;
				hold_full_q <= 1'b1;
			end else if (tx_load) begin
				hold_full_q <= 1'b0;
			end
			if (tx_load) begin
				// Loading only on a bit clock edge keeps the start bit full width.
				tx_st_q   <= TX_SHIFT;
				frame_q   <= frame_d;
				tx_sub_q  <= 4'h0;
				tx_bits_q <= nbits_d;
				eoc_q     <= 1'b0;
			end else if (tx_last) begin
				tx_st_q <= TX_IDLE;
				frame_q <= 12'hFFF;
				eoc_q   <= 1'b1;
			end else if (tx_st_q == TX_SHIFT && tx_tick) begin
				tx_sub_q <= tx_sub_q + 4'h1;
				if (tx_sub_q == `AST_TICKS_BIT) begin
					frame_q   <= {1'b1, frame_q[11:1]};
					tx_bits_q <= tx_bits_q - 4'h1;
				end
			end
			serial_out_q <= tx_st_q == TX_SHIFT ? frame_q[0] : 1'b1;
		end
	end

	// Receiver: start validation, mid-bit sampling, output latch.
	reg  [1:0]  rx_st_q;
	reg  [3:0]  rx_sub_q;
	reg  [3:0]  rx_idx_q;
	reg  [7:0]  rx_shift_q;
	reg         rx_par_q;
	reg         ferr_pend_q;
	reg         ovr_pend_q;
	reg  [7:0]  rx_data_q;
	reg         perr_q;
	reg         ferr_q;
	reg         ovr_q;
	reg         avail_q;
	wire [3:0]  stop_idx = len + {3'b000, par_en};
	wire        rx_samp  = rx_tick && rx_sub_q == `AST_TICKS_BIT;
	wire        rx_done  = rx_st_q == RX_XFER && rx_tick;
	wire        par_bad  = par_en && (^(rx_shift_q & len_mask) ^ rx_par_q ^
		~ctrl_q[`AST_CTRL_EVEN]);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q     <= RX_IDLE;
			rx_sub_q    <= 4'h0;
			rx_idx_q    <= 4'h0;
			rx_shift_q  <= 8'h00;
			rx_par_q    <= 1'b0;
			ferr_pend_q <= 1'b0;
			ovr_pend_q  <= 1'b0;
			rx_data_q   <= 8'h00;
			perr_q      <= 1'b0;
			ferr_q      <= 1'b0;
			ovr_q       <= 1'b0;
			avail_q     <= 1'b0;
		end else if (clr) begin
			rx_st_q     <= RX_IDLE;
			rx_sub_q    <= 4'h0;
			rx_idx_q    <= 4'h0;
			rx_shift_q  <= 8'h00;
			rx_par_q    <= 1'b0;
			ferr_pend_q <= 1'b0;
			ovr_pend_q  <= 1'b0;
			rx_data_q   <= 8'h00;
			perr_q      <= 1'b0;
			ferr_q      <= 1'b0;
			ovr_q       <= 1'b0;
			avail_q     <= 1'b0;
		end else begin
			case (rx_st_q)
			RX_IDLE: begin
				rx_sub_q <= 4'h0;
				if (rx_tick && !rx_line)
					rx_st_q <= RX_START;
			end
			RX_START: begin
				if (rx_tick) begin
					if (rx_line) begin
						rx_st_q <= RX_IDLE;
					end else if (rx_sub_q == `AST_TICKS_START) begin
						rx_st_q  <= RX_DATA;
						rx_sub_q <= 4'h0;
						rx_idx_q <= 4'h0;
					end else begin
						rx_sub_q <= rx_sub_q + 4'h1;
					end
				end
			end
			RX_DATA: begin
				if (rx_tick)
					rx_sub_q <= rx_sub_q + 4'h1;
				// Sampling mid-bit tolerates heavy edge distortion.
				if (rx_samp) begin
					rx_idx_q <= rx_idx_q + 4'h1;
					if (rx_idx_q < len)
						rx_shift_q[rx_idx_q[2:0]] <= rx_line;
					else if (rx_idx_q != stop_idx)
						rx_par_q <= rx_line;
					if (rx_idx_q == stop_idx) begin
						ferr_pend_q <= ~rx_line;
						ovr_pend_q  <= avail_q;
						rx_st_q     <= RX_XFER;
					end
				end
			end
			RX_XFER: begin
				if (rx_tick) begin
					rx_data_q <= rx_shift_q & len_mask;
					perr_q    <= par_bad;
					ferr_q    <= ferr_pend_q;
					ovr_q     <= ovr_pend_q;
					rx_st_q   <= RX_IDLE;
				end
			end
			default: rx_st_q <= RX_IDLE;
			endcase
			// Set wins over the clear made by reading the data register.
			if (rx_done)
				avail_q <= 1'b1;
			else if (rd_rx)
				avail_q <= 1'b0;
			if (rx_st_q == RX_IDLE)
				rx_shift_q <= rx_idx_q == 4'h0 ? rx_shift_q : 8'h00;
		end
	end

	// Status, interrupts and the register read port.
	wire [5:0]  status = {ovr_q, ferr_q, perr_q, avail_q, eoc_q, ~hold_full_q};
	reg  [3:0]  irq_stat_q;
	reg  [3:0]  irq_mask_q;
	wire [3:0]  irq_ev;

	assign irq_ev[`AST_IRQ_TBMT]  = tx_load;
	assign irq_ev[`AST_IRQ_EOC]   = tx_last && !hold_full_q;
	assign irq_ev[`AST_IRQ_AVAIL] = rx_done;
	assign irq_ev[`AST_IRQ_ERR]   = rx_done &&
		(par_bad | ferr_pend_q | ovr_pend_q);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q          <= `AST_IRQ_RST;
			irq_mask_q          <= `AST_IRQ_RST;
			irq_q               <= 1'b0;
			reg_rdata_q         <= 8'h00;
			rx_word_q           <= 8'h00;
			flag_word_q         <= 5'h00;
			rx_word_available_q <= 1'b0;
		end else begin
			irq_stat_q <= irq_ev | (rd_irq ? 4'h0 : irq_stat_q);
			if (reg_wr && reg_addr == `AST_OFF_IRQ_MASK)
				irq_mask_q <= reg_wdata[3:0];
			irq_q <= |(irq_stat_q & irq_mask_q);
			reg_rdata_q <= 8'h00;
			if (reg_rd) begin
				case (reg_addr)
				`AST_OFF_CTRL:     reg_rdata_q <= {3'h0, ctrl_q};
				`AST_OFF_TXDATA:   reg_rdata_q <= hold_q;
				`AST_OFF_RXDATA:   reg_rdata_q <= rx_data_q;
				`AST_OFF_STATUS:   reg_rdata_q <= {2'h0, status};
				`AST_OFF_IRQ_STAT: reg_rdata_q <= {4'h0, irq_stat_q};
				`AST_OFF_IRQ_MASK: reg_rdata_q <= {4'h0, irq_mask_q};
				default:           reg_rdata_q <= 8'h00;
				endcase
			end
			// Disabled groups drive zero so outputs can be ORed on a bus.
			rx_word_q   <= rde_s_q[1] ? 8'h00 : rx_data_q;
			flag_word_q <= swe_s_q[1] ? 5'h00 :
				{ovr_q, ferr_q, perr_q, eoc_q, ~hold_full_q};
			rx_word_available_q <= avail_q;
		end
	end

endmodule // ast_transceiver

// ===== testbench/ast_line_peer.sv
`timescale 1ns/10ps
module ast_line_peer (
	output logic bit_clk = 1'b0, // Shared 16x bit clock.
	output logic line = 1'b1     // Serial line, mark when idle.
);
	// Each phase lasts four system clocks, above the synchroniser limit.
	always #160 bit_clk = ~bit_clk;
	task automatic send(input logic [11:0] bits);
		for (int i = 0; i < 12; i++) begin
			@(posedge bit_clk);
			line <= bits[i];
			repeat (15) @(posedge bit_clk);
		end
	endtask
	task automatic glitch();
		@(posedge bit_clk);
		line <= 1'b0;
		repeat (4) @(posedge bit_clk);
		line <= 1'b1;
	endtask
endmodule // ast_line_peer

// ===== testbench/ast_monitor.sv
`timescale 1ns/10ps
`include "ast_regs.vh"
module ast_monitor #(
	parameter AW = 4
) (
	input wire          sys_clk, // Clock.
	input wire          rst_n, // Reset.
	input wire [AW-1:0] reg_addr, // Address.
	input wire [7:0]    reg_wdata, // Write data.
	input wire          reg_wr, // Write.
	input wire          reg_rd, // Read.
	input wire          irq_q, // Interrupt.
	input wire          tx_bit_clock, // Tx clock.
	input wire          external_clear, // Clear.
	input wire          serial_out_q, // Tx line.
	input wire          rx_word_output_enable_n, // Data enable.
	input wire          flag_word_output_enable_n, // Flag enable.
	input wire [7:0]    rx_word_q, // Data out.
	input wire [4:0]    flag_word_q, // Flags out.
	input wire          rx_word_available_q // Data ready.
);
	reg [3:0] mask_q;
	reg [3:0] gap_q;
	reg       tck_q;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// The mask is shadowed so that irq can be tied to what software enabled.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= 4'h0;
			gap_q <= 4'h0;
			tck_q <= 1'b0;
		end else begin
			tck_q <= tx_bit_clock;
			if (reg_wr && reg_addr == `AST_OFF_IRQ_MASK)
				mask_q <= reg_wdata[3:0];
			if (tx_bit_clock && !tck_q)
				gap_q <= 4'h0;
			else if (gap_q != 4'hF)
				gap_q <= gap_q + 4'h1;
		end
	end
	property p_flag_off;
		flag_word_output_enable_n [*4] |=> flag_word_q == 5'h00;
	endproperty
	a_flag_off: assert property (p_flag_off)
		else $error("flag group driven while disabled");
	property p_word_off;
		rx_word_output_enable_n [*4] |=> rx_word_q == 8'h00;
	endproperty
	a_word_off: assert property (p_word_off)
		else $error("data group driven while disabled");
	// Sync delay allows a few cycles, but never a move between ticks.
	property p_tx_tick;
		$changed(serial_out_q) |-> gap_q inside {[1:5]};
	endproperty
	a_tx_tick: assert property (p_tx_tick)
		else $error("serial output moved away from a bit clock tick");
	property p_clear;
		external_clear [*5] |=> serial_out_q && !rx_word_available_q;
	endproperty
	a_clear: assert property (p_clear)
		else $error("clear did not idle the line and receiver");
	property p_tbmt_wr;
		reg_wr && reg_addr == `AST_OFF_TXDATA |-> ##[1:3] !flag_word_q[0];
	endproperty
	a_tbmt_wr: assert property (p_tbmt_wr)
		else $error("holding empty flag ignored a load");
	property p_eoc_start;
		$fell(serial_out_q) |-> ##[0:3] !flag_word_q[1];
	endproperty
	a_eoc_start: assert property (p_eoc_start)
		else $error("end of character flag kept over a start bit");
	property p_avail_rd;
		reg_rd && reg_addr == `AST_OFF_RXDATA |-> ##2 !rx_word_available_q;
	endproperty
	a_avail_rd: assert property (p_avail_rd)
		else $error("data read did not clear data available");
	property p_irq_mask;
		irq_q |-> $past(mask_q) != 4'h0;
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt raised with all events masked");
endmodule // ast_monitor

bind ast_transceiver ast_monitor #(.AW(AW)) mon (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.irq_q(irq_q),
	.tx_bit_clock(tx_bit_clock),
	.external_clear(external_clear),
	.serial_out_q(serial_out_q),
	.rx_word_output_enable_n(rx_word_output_enable_n),
	.flag_word_output_enable_n(flag_word_output_enable_n),
	.rx_word_q(rx_word_q),
	.flag_word_q(flag_word_q),
	.rx_word_available_q(rx_word_available_q)
);

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
`include "ast_regs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("Error at %0t: got %h want %h", $time, g, e); end end
module tb_top;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ext_clr = 1'b0;
	logic        rx_oe_n = 1'b0;
	logic        fl_oe_n = 1'b0;
	logic        bclk;
	logic        line;
	wire  [7:0]  rdata;
	wire  [7:0]  rxw;
	wire  [4:0]  flags;
	wire         irq;
	wire         so;
	wire         avail;
	int          mismatches = 0;
	int          check_count = 0;
	int          n_t[4] = '{5, 6, 7, 8};
	int          p_t[4] = '{1, 2, 0, 2};
	logic [7:0]  c_t[4] = '{8'h00, 8'h19, 8'h06, 8'h1B};
	logic [7:0]  v;
	logic [7:0]  r;
	logic [11:0] f;
	logic [11:0] f2;
	logic [23:0] got;
	always #20 sys_clk = ~sys_clk;
	ast_line_peer peer (.bit_clk(bclk), .line(line));
	ast_transceiver uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(rdata), .irq_q(irq),
		.tx_bit_clock(bclk), .rx_bit_clock(bclk), .external_clear(ext_clr),
		.serial_in(line), .serial_out_q(so), .rx_word_q(rxw),
		.rx_word_output_enable_n(rx_oe_n), .flag_word_q(flags),
		.flag_word_output_enable_n(fl_oe_n), .rx_word_available_q(avail));
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = rdata;
	endtask
	task results();
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Samples mid-bit; chained frames keep the same phase.
	task cap(input int n, output logic [23:0] b);
		int k;
		b = 24'hFFFFFF;
		k = 0;
		while (so === 1'b1 && k < 4000) begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 4000) begin
			mismatches++;
			results();
		end else begin
			repeat (64) @(posedge sys_clk);
			for (int i = 0; i < n; i++) begin
				b[i] = so;
				repeat (128) @(posedge sys_clk);
			end
		end
	endtask
	function automatic logic [11:0] frame(logic [7:0] d, int n, int p);
		logic [11:0] q;
		q = 12'hFFE;
		for (int i = 0; i < n; i++)
			q[i + 1] = d[i];
		if (p != 0)
			q[n + 1] = (^(d & ~(8'hFF << n))) ^ (p == 1);
		return q;
	endfunction
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(`AST_OFF_CTRL, r);
		`CHK(r, 8'h04)
		rd(4'hE, r);
		`CHK(so, 1'b1)
		$display("Test reset done");
		for (int i = 0; i < 4; i++) begin
			v = 8'h35 + 8'(i * 75);
			f = frame(v, n_t[i], p_t[i]);
			wr(`AST_OFF_CTRL, c_t[i]);
			wr(`AST_OFF_TXDATA, v);
			fork
				peer.send(f);
				cap(12, got);
			join
			`CHK(got[11:0], f)
			`CHK(avail, 1'b1)
			`CHK(rxw, v & ~(8'hFF << n_t[i]))
			`CHK(flags[4:2], 3'b000)
			rd(`AST_OFF_RXDATA, r);
			`CHK(r, v & ~(8'hFF << n_t[i]))
		end
		$display("Test duplex done");
		wr(`AST_OFF_CTRL, 8'h0B);
		f = frame(8'h5A, 8, 2);
		for (int k = 0; k < 3; k++) begin
			if (k == 2)
				peer.send(f);
			peer.send(k == 0 ? f ^ 12'h200 : k == 1 ? f & 12'hBFF : f);
			`CHK(flags[4:2], 3'b001 << k)
			rd(`AST_OFF_RXDATA, r);
		end
		peer.glitch();
		// Long enough for a wrongly accepted start to finish a character.
		repeat (1600) @(posedge sys_clk);
		`CHK(avail, 1'b0)
		$display("Test receive errors done");
		wr(`AST_OFF_CTRL, 8'h17);
		fork
			cap(22, got);
			begin
				wr(`AST_OFF_TXDATA, 8'hC3);
				repeat (40) @(posedge sys_clk);
				`CHK(flags[0], 1'b1)
				wr(`AST_OFF_TXDATA, 8'h3C);
			end
		join
		f = frame(8'hC3, 8, 0);
		f2 = frame(8'h3C, 8, 0);
		`CHK(got[10:0], f[10:0])
		`CHK(got[21:11], f2[10:0])
		`CHK(flags[1:0], 2'b11)
		rd(`AST_OFF_STATUS, r);
		`CHK(r, 8'h23)
		rd(`AST_OFF_TXDATA, r);
		`CHK(r, 8'h3C)
		$display("Test holding register done");
		rd(`AST_OFF_IRQ_STAT, r);
		`CHK(r, 8'h0F)
		wr(`AST_OFF_IRQ_MASK, 8'h04);
		wr(`AST_OFF_CTRL, 8'h0B);
		peer.send(frame(8'h5A, 8, 2));
		`CHK(irq, 1'b1)
		rd(`AST_OFF_IRQ_STAT, r);
		`CHK(r, 8'h04)
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b0)
		rx_oe_n <= 1'b1;
		fl_oe_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		`CHK(rxw, 8'h00)
		`CHK(flags, 5'h00)
		ext_clr <= 1'b1;
		repeat (8) @(posedge sys_clk);
		ext_clr <= 1'b0;
		repeat (4) @(posedge sys_clk);
		`CHK(avail, 1'b0)
		rd(`AST_OFF_CTRL, r);
		`CHK(r, 8'h04)
		$display("Test interrupt and clear done");
		results();
	end
endmodule // tb_top
